// ==== inc/tgc_pkg.sv ====
/*
 * Shared constants and types of the thermal gauge command handler.
 * Assumes byte-wide ASCII traffic from a UART outside the block.
 */
package tgc_pkg;
  localparam int NCH = 10;
  localparam int CHW = 4;
  ////////////////////////////////////////////////////////////////////////
  // Characters
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_ACK = 8'h3e;
  localparam logic [7:0] CH_NAK = 8'h3f;
  localparam logic [7:0] CH_CV1 = 8'h34;
  localparam logic [7:0] CH_CV2 = 8'h35;
  localparam logic [7:0] ST_PIR = 8'h33;
  ////////////////////////////////////////////////////////////////////////
  // Opcodes, three ASCII characters
  localparam logic [23:0] OP_POWER = 24'h303831;
  localparam logic [23:0] OP_STYPE = 24'h303639;
  localparam logic [23:0] OP_GAS = 24'h303633;
  localparam logic [23:0] OP_CVAR = 24'h303638;
  localparam logic [23:0] OP_UZERO = 24'h303536;
  localparam logic [23:0] OP_ZERO = 24'h303531;
  localparam logic [23:0] OP_AZREF = 24'h303539;
  localparam logic [23:0] OP_AZEN = 24'h303538;
  localparam logic [23:0] OP_SPANEN = 24'h303537;
  localparam logic [23:0] OP_SPANATM = 24'h303533;
  localparam logic [23:0] OP_RDG = 24'h363031;
  localparam logic [23:0] OP_RDGTS = 24'h363032;
  localparam logic [23:0] OP_VOLT = 24'h363033;
  localparam logic [23:0] OP_LEAK = 24'h363036;
  localparam logic [23:0] OP_STAT = 24'h363038;
  ////////////////////////////////////////////////////////////////////////
  // Register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_REJ = 4'h2;
  localparam int CTRL_EN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REJ = 1;
  localparam logic EN_RST = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    P_HUNT = 2'b00, P_OP = 2'b01, P_ID = 2'b10, P_ARG = 2'b11
  } tgc_pst_e;
  typedef struct packed {
    logic [23:0] op;
    logic [7:0] id;
    logic [7:0] arg0;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [1:0] argn;
    logic query;
    logic bad;
  } tgc_cmd_t;
  typedef struct packed {
    tgc_pst_e st;
    logic [1:0] opn;
    logic full;
    tgc_cmd_t cmd;
  } tgc_prs_t;
  typedef enum logic [1:0] {
    GAS_N = 2'b00, GAS_H = 2'b01, GAS_A = 2'b10
  } tgc_gas_e;
  typedef struct packed {
    logic power;
    logic cvar2;
    tgc_gas_e gas;
    logic uzero;
    logic azero;
    logic [CHW-1:0] azref;
    logic span;
  } tgc_cfg_t;
  localparam tgc_cfg_t CFG_RST = '{power: 1'b0, cvar2: 1'b0, gas: GAS_N,
    uzero: 1'b0, azero: 1'b0, azref: 4'h0, span: 1'b0};
  typedef struct packed {
    logic installed;
    logic in_range;
    logic under_range;
    logic convection;
  } tgc_sens_t;
  typedef enum logic [2:0] {
    RPT_RDG = 3'b000, RPT_RDGTS = 3'b001, RPT_VOLT = 3'b010,
    RPT_LEAK = 3'b011, RPT_STAT = 3'b100
  } tgc_rpt_e;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00, T_CHAR = 2'b01, T_CR = 2'b10
  } tgc_tst_e;
  typedef struct packed {
    tgc_tst_e st;
    logic [7:0] data;
  } tgc_tx_t;
  typedef enum logic {H_IDLE = 1'b0, H_EXEC = 1'b1} tgc_hst_e;
endpackage

// ==== src/tgc_parser.sv ====
/*
 * Frames the received byte stream into commands.
 * Assumes rx bytes are synchronous to clk, one per rx_valid cycle.
 */
`timescale 1ns/1ps
module tgc_parser (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output logic rx_ready,
  output logic cmd_valid,
  output tgc_pkg::tgc_cmd_t cmd,
  input wire cmd_ready
);
  tgc_pkg::tgc_prs_t r;
  tgc_pkg::tgc_prs_t next_r;

  assign rx_ready = !r.full;
  assign cmd_valid = r.full;
  assign cmd = r.cmd;

  always_comb begin
    next_r = r;
    if (r.full && cmd_ready) begin
      next_r.full = 1'b0;
    end
    if (!r.full && rx_valid) begin
      if (rx_data == tgc_pkg::CH_AT) begin
        next_r.st = tgc_pkg::P_OP;
        next_r.opn = 2'b00;
        next_r.cmd = '0;
      end else if (rx_data == tgc_pkg::CH_CR) begin
        if (r.st != tgc_pkg::P_HUNT) begin
          next_r.full = 1'b1;
          next_r.st = tgc_pkg::P_HUNT;
          if (r.st == tgc_pkg::P_OP || r.st == tgc_pkg::P_ID) begin
            next_r.cmd.bad = 1'b1;
          end
        end
      end else begin
        case (r.st)
          tgc_pkg::P_OP: begin
            next_r.cmd.op = {r.cmd.op[15:0], rx_data};
            next_r.opn = r.opn + 2'b01;
            if (r.opn == 2'b10) begin
              next_r.st = tgc_pkg::P_ID;
            end
          end
          tgc_pkg::P_ID: begin
            next_r.cmd.id = rx_data;
            next_r.st = tgc_pkg::P_ARG;
          end
          tgc_pkg::P_ARG: begin
            if (rx_data == tgc_pkg::CH_QM) begin
              next_r.cmd.query = 1'b1;
            end else if (rx_data != tgc_pkg::CH_COLON) begin
              case (r.cmd.argn)
                2'b00: next_r.cmd.arg0 = rx_data;
                2'b01: next_r.cmd.arg1 = rx_data;
                2'b10: next_r.cmd.arg2 = rx_data;
                default: next_r.cmd.bad = 1'b1;
              endcase
              if (r.cmd.argn != 2'b11) begin
                next_r.cmd.argn = r.cmd.argn + 2'b01;
              end
            end
          end
          default: next_r.st = tgc_pkg::P_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // tgc_parser

// ==== src/tgc_tx.sv ====
/*
 * Sends a one-character answer followed by carriage return.
 * Assumes the UART transmitter outside takes a byte when tx_ready is high.
 */
`timescale 1ns/1ps
module tgc_tx (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire send,
  input wire [7:0] send_byte,
  output logic idle,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire tx_ready
);
  tgc_pkg::tgc_tx_t r;
  tgc_pkg::tgc_tx_t next_r;

  assign idle = (r.st == tgc_pkg::T_IDLE);
  assign tx_valid = !idle;
  assign tx_data = r.data;

  always_comb begin
    next_r = r;
    case (r.st)
      tgc_pkg::T_IDLE: begin
        if (send) begin
          next_r.st = tgc_pkg::T_CHAR;
          next_r.data = send_byte;
        end
      end
      tgc_pkg::T_CHAR: begin
        if (tx_ready) begin
          next_r.st = tgc_pkg::T_CR;
          next_r.data = tgc_pkg::CH_CR;
        end
      end
      tgc_pkg::T_CR: begin
        if (tx_ready) begin
          next_r.st = tgc_pkg::T_IDLE;
        end
      end
      default: next_r.st = tgc_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // tgc_tx

// ==== src/tgc_handler.sv ====
/*
 * Command interpreter for ten thermal-conductivity gauge channels.
 * Assumes a UART outside delivers and takes bytes, and that sensor
 * status and measurement formatting are provided by logic around it.
 */
// Notes on behaviour
// - Each message names a channel, digits 1 to 9 and then 0 for ten.
// - Every command and request ends with a carriage return.
// - The block takes Pirani or convection gauge detection from the sensor interface.
// - Variant code 4 selects the first variant, 5 the second; first is default.
// - Sensor type answers 3, 4 or 5, only when powered and in range.
// - Gas type takes N, H or A, and nitrogen is the default.
// - Zero channel has no argument and acts only in range or underrange.
// - Auto-zero reference needs both sensors installed; E enables auto-zero and D disables it.
// - Span to atmosphere has no argument and turns the span function on.
// - Status, reading and stamped reading need power and in-range.
// - Sensor voltage, in volts, needs the sensor installed and powered.
`timescale 1ns/1ps
module tgc_handler (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire tx_ready,
  input tgc_pkg::tgc_sens_t [tgc_pkg::NCH-1:0] sens,
  output tgc_pkg::tgc_cfg_t [tgc_pkg::NCH-1:0] cfg,
  output logic [tgc_pkg::NCH-1:0] conv_detect,
  output logic [tgc_pkg::NCH-1:0] zero_pulse,
  output logic [tgc_pkg::NCH-1:0] span_pulse,
  output logic rpt_valid,
  output tgc_pkg::tgc_rpt_e rpt_kind,
  output logic [tgc_pkg::CHW-1:0] rpt_chan,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output logic [7:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tgc_pkg::tgc_hst_e fsm;
    tgc_pkg::tgc_cmd_t cmd;
    tgc_pkg::tgc_cfg_t [tgc_pkg::NCH-1:0] cfg;
    logic [tgc_pkg::NCH-1:0] zero_p;
    logic [tgc_pkg::NCH-1:0] span_p;
    logic rpt_valid;
    tgc_pkg::tgc_rpt_e rpt_kind;
    logic [tgc_pkg::CHW-1:0] rpt_chan;
    logic send;
    logic [7:0] send_byte;
    logic enable;
    logic last_rej;
    logic [7:0] rej_cnt;
    logic [7:0] rdata;
  } tgc_hs_t;

  tgc_hs_t r;
  tgc_hs_t next_r;
  logic cmd_valid;
  tgc_pkg::tgc_cmd_t cmd;
  logic cmd_ready;
  logic tx_idle;
  logic [7:0] stype [tgc_pkg::NCH];

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic arg_on(input tgc_pkg::tgc_cmd_t c);
    arg_on = c.argn == 2'b10 && c.arg0 == tgc_pkg::CH_O &&
             c.arg1 == tgc_pkg::CH_N;
  endfunction

  function automatic logic arg_off(input tgc_pkg::tgc_cmd_t c);
    arg_off = c.argn == 2'b11 && c.arg0 == tgc_pkg::CH_O &&
              c.arg1 == tgc_pkg::CH_F && c.arg2 == tgc_pkg::CH_F;
  endfunction

  function automatic logic arg_one(input tgc_pkg::tgc_cmd_t c,
                                   input logic [7:0] ch);
    arg_one = c.argn == 2'b01 && c.arg0 == ch;
  endfunction

  function automatic logic is_digit(input logic [7:0] ch);
    is_digit = ch >= tgc_pkg::CH_0 && ch <= tgc_pkg::CH_9;
  endfunction

  // Digit 1..9 maps to channel 0..8, digit 0 to channel 9
  function automatic logic [tgc_pkg::CHW-1:0] chan_of(input logic [7:0] ch);
    logic [7:0] d;
    d = ch - tgc_pkg::CH_1;
    if (ch == tgc_pkg::CH_0) begin
      chan_of = tgc_pkg::CHW'(tgc_pkg::NCH - 1);
    end else if (is_digit(ch)) begin
      chan_of = d[tgc_pkg::CHW-1:0];
    end else begin
      chan_of = '0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  tgc_parser u_parser (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .cmd_ready(cmd_ready)
  );

  tgc_tx u_tx (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .send(r.send),
    .send_byte(r.send_byte),
    .idle(tx_idle),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-channel gauge kind

  genvar gi;
  generate
    for (gi = 0; gi < tgc_pkg::NCH; gi++) begin : g_ch
      // Detection comes from the sensor interface, the variant from the host
      always_comb begin
        if (sens[gi].convection) begin
          stype[gi] = r.cfg[gi].cvar2 ? tgc_pkg::CH_CV2 : tgc_pkg::CH_CV1;
        end else begin
          stype[gi] = tgc_pkg::ST_PIR;
        end
      end
      assign conv_detect[gi] = sens[gi].convection;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cfg = r.cfg;
  assign zero_pulse = r.zero_p;
  assign span_pulse = r.span_p;
  assign rpt_valid = r.rpt_valid;
  assign rpt_kind = r.rpt_kind;
  assign rpt_chan = r.rpt_chan;
  assign reg_rdata = r.rdata;
  // A command is taken only when the answer path is free
  assign cmd_ready = r.fsm == tgc_pkg::H_IDLE && r.enable && tx_idle &&
                     !r.send;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [tgc_pkg::CHW-1:0] ch;
    logic [tgc_pkg::CHW-1:0] rch;
    tgc_pkg::tgc_sens_t s;
    logic ok;
    logic reply;
    logic [7:0] ans;
    ch = '0;
    rch = '0;
    s = '0;
    ok = 1'b0;
    reply = 1'b1;
    ans = tgc_pkg::CH_ACK;
    next_r = r;
    next_r.zero_p = '0;
    next_r.span_p = '0;
    next_r.rpt_valid = 1'b0;
    next_r.send = 1'b0;

    // Register port
    if (reg_wr && reg_addr == tgc_pkg::REG_CTRL) begin
      next_r.enable = reg_wdata[tgc_pkg::CTRL_EN];
    end
    next_r.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        tgc_pkg::REG_CTRL: next_r.rdata[tgc_pkg::CTRL_EN] = r.enable;
        tgc_pkg::REG_STAT: begin
          next_r.rdata[tgc_pkg::STAT_BUSY] = r.fsm != tgc_pkg::H_IDLE ||
                                             !tx_idle;
          next_r.rdata[tgc_pkg::STAT_REJ] = r.last_rej;
        end
        tgc_pkg::REG_REJ: next_r.rdata = r.rej_cnt;
        default: next_r.rdata = '0;
      endcase
    end

    case (r.fsm)
      tgc_pkg::H_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_r.cmd = cmd;
          next_r.fsm = tgc_pkg::H_EXEC;
        end
      end
      tgc_pkg::H_EXEC: begin
        next_r.fsm = tgc_pkg::H_IDLE;
        ch = chan_of(r.cmd.id);
        s = sens[ch];
        if (!r.cmd.bad && is_digit(r.cmd.id)) begin
          case (r.cmd.op)
            tgc_pkg::OP_POWER: begin
              ok = s.installed && !r.cmd.query &&
                   (arg_on(r.cmd) || arg_off(r.cmd));
              if (ok) begin
                next_r.cfg[ch].power = arg_on(r.cmd);
              end
            end
            tgc_pkg::OP_STYPE: begin
              ok = r.cmd.query && r.cfg[ch].power && s.in_range;
              ans = stype[ch];
            end
            tgc_pkg::OP_GAS: begin
              ok = !r.cmd.query && (arg_one(r.cmd, tgc_pkg::CH_N) ||
                   arg_one(r.cmd, tgc_pkg::CH_H) ||
                   arg_one(r.cmd, tgc_pkg::CH_A));
              if (ok) begin
                if (arg_one(r.cmd, tgc_pkg::CH_H)) begin
                  next_r.cfg[ch].gas = tgc_pkg::GAS_H;
                end else if (arg_one(r.cmd, tgc_pkg::CH_A)) begin
                  next_r.cfg[ch].gas = tgc_pkg::GAS_A;
                end else begin
                  next_r.cfg[ch].gas = tgc_pkg::GAS_N;
                end
              end
            end
            tgc_pkg::OP_CVAR: begin
              // Taken whether or not a convection gauge is seen
              ok = !r.cmd.query && (arg_one(r.cmd, tgc_pkg::CH_CV1) ||
                   arg_one(r.cmd, tgc_pkg::CH_CV2));
              if (ok) begin
                next_r.cfg[ch].cvar2 = arg_one(r.cmd, tgc_pkg::CH_CV2);
              end
            end
            tgc_pkg::OP_UZERO: begin
              ok = s.installed && !r.cmd.query &&
                   (arg_on(r.cmd) || arg_off(r.cmd));
              if (ok) begin
                next_r.cfg[ch].uzero = arg_on(r.cmd);
              end
            end
            tgc_pkg::OP_ZERO: begin
              ok = r.cmd.argn == 2'b00 && !r.cmd.query &&
                   (s.in_range || s.under_range);
              if (ok) begin
                next_r.zero_p[ch] = 1'b1;
              end
            end
            tgc_pkg::OP_AZREF: begin
              rch = chan_of(r.cmd.arg0);
              ok = !r.cmd.query && r.cmd.argn == 2'b01 &&
                   is_digit(r.cmd.arg0) && s.installed &&
                   sens[rch].installed;
              if (ok) begin
                next_r.cfg[ch].azref = rch;
              end
            end
            tgc_pkg::OP_AZEN: begin
              ok = !r.cmd.query && (arg_one(r.cmd, tgc_pkg::CH_E) ||
                   arg_one(r.cmd, tgc_pkg::CH_D));
              if (ok) begin
                next_r.cfg[ch].azero = arg_one(r.cmd, tgc_pkg::CH_E);
              end
            end
            tgc_pkg::OP_SPANEN: begin
              ok = !r.cmd.query && (arg_on(r.cmd) || arg_off(r.cmd));
              if (ok) begin
                next_r.cfg[ch].span = arg_on(r.cmd);
              end
            end
            tgc_pkg::OP_SPANATM: begin
              ok = r.cmd.argn == 2'b00 && !r.cmd.query;
              if (ok) begin
                next_r.cfg[ch].span = 1'b1;
                next_r.span_p[ch] = 1'b1;
              end
            end
            tgc_pkg::OP_RDG, tgc_pkg::OP_RDGTS, tgc_pkg::OP_STAT: begin
              ok = r.cmd.query && r.cfg[ch].power && s.in_range;
              reply = !ok;
              if (r.cmd.op == tgc_pkg::OP_RDG) begin
                next_r.rpt_kind = tgc_pkg::RPT_RDG;
              end else if (r.cmd.op == tgc_pkg::OP_RDGTS) begin
                next_r.rpt_kind = tgc_pkg::RPT_RDGTS;
              end else begin
                next_r.rpt_kind = tgc_pkg::RPT_STAT;
              end
            end
            tgc_pkg::OP_VOLT: begin
              ok = r.cmd.query && s.installed && r.cfg[ch].power;
              reply = !ok;
              next_r.rpt_kind = tgc_pkg::RPT_VOLT;
            end
            tgc_pkg::OP_LEAK: begin
              ok = r.cmd.query && s.installed;
              reply = !ok;
              next_r.rpt_kind = tgc_pkg::RPT_LEAK;
            end
            default: ok = 1'b0;
          endcase
        end
        // Refusal answers and leaves every setting as it was
        if (!ok) begin
          next_r.cfg = r.cfg;
          next_r.zero_p = '0;
          next_r.span_p = '0;
          next_r.rpt_kind = r.rpt_kind;
          ans = tgc_pkg::CH_NAK;
          reply = 1'b1;
          next_r.rej_cnt = r.rej_cnt + 8'h01;
        end
        next_r.last_rej = !ok;
        next_r.rpt_valid = ok && !reply;
        next_r.rpt_chan = ok && !reply ? ch : r.rpt_chan;
        next_r.send = reply;
        next_r.send_byte = ans;
      end
      default: next_r.fsm = tgc_pkg::H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.cfg <= {tgc_pkg::NCH{tgc_pkg::CFG_RST}};
      r.enable <= tgc_pkg::EN_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

endmodule // tgc_handler

// ==== sim/tgc_handler_sva.sv ====
/* Port checks of the gauge command handler.
   Assumes sens holds steady while a command runs. */
`timescale 1ns/1ps
module tgc_handler_sva (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready,
  input tgc_pkg::tgc_sens_t [tgc_pkg::NCH-1:0] sens,
  input tgc_pkg::tgc_cfg_t [tgc_pkg::NCH-1:0] cfg,
  input wire [tgc_pkg::NCH-1:0] zero_pulse,
  input wire [tgc_pkg::NCH-1:0] span_pulse,
  input wire rpt_valid,
  input tgc_pkg::tgc_rpt_e rpt_kind,
  input wire [tgc_pkg::CHW-1:0] rpt_chan,
  input wire reg_rd,
  input wire [7:0] reg_rdata
);
  logic [tgc_pkg::NCH-1:0] zok, spn, sp_q;
  always_comb begin
    for (int i = 0; i < tgc_pkg::NCH; i++) begin
      zok[i] = sens[i].in_range | sens[i].under_range;
      spn[i] = cfg[i].span;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sp_q <= '0;
    else sp_q <= span_pulse;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  property p_cr_frame;
    ce && rx_valid && rx_ready && rx_data == tgc_pkg::CH_CR |=> !rx_ready;
  endproperty
  a_cr_frame: assert property (p_cr_frame) else $error("no hold at CR");
  property p_reset_cfg;
    $rose(reset_n) |-> cfg == {tgc_pkg::NCH{tgc_pkg::CFG_RST}};
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad defaults");
  property p_zero_range;
    |zero_pulse |-> (zero_pulse & ~zok) == '0;
  endproperty
  a_zero_range: assert property (p_zero_range) else $error("zero out of range");
  property p_span_on;
    |sp_q |-> (sp_q & ~spn) == '0;
  endproperty
  a_span_on: assert property (p_span_on) else $error("span left off");
  property p_rpt_range;
    rpt_valid && rpt_kind inside {tgc_pkg::RPT_RDG, tgc_pkg::RPT_RDGTS,
      tgc_pkg::RPT_STAT} |-> cfg[rpt_chan].power && sens[rpt_chan].in_range;
  endproperty
  a_rpt_range: assert property (p_rpt_range) else $error("report refused");
  property p_volt_pwr;
    rpt_valid && rpt_kind == tgc_pkg::RPT_VOLT
      |-> cfg[rpt_chan].power && sens[rpt_chan].installed;
  endproperty
  a_volt_pwr: assert property (p_volt_pwr) else $error("volt refused");
  property p_rpt_pulse;
    rpt_valid |=> !rpt_valid;
  endproperty
  a_rpt_pulse: assert property (p_rpt_pulse) else $error("long report");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("answer dropped");
  property p_rdata_zero;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("stray rdata");
endmodule // tgc_handler_sva
bind tgc_handler tgc_handler_sva chk (.clk, .reset_n, .ce, .rx_valid,
  .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .sens, .cfg,
  .zero_pulse, .span_pulse, .rpt_valid, .rpt_kind, .rpt_chan, .reg_rd,
  .reg_rdata);

// ==== sim/tgc_host.sv ====
/* Host model on the byte link: sends framed messages, takes answers.
   Assumes the handshake of the handler's byte ports. */
`timescale 1ns/1ps
module tgc_host (
  input wire clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire rx_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] ans[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Stalls every other cycle when slow
  always @(posedge clk) begin
    if (tx_valid && tx_ready) ans.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // Message text carries the channel digit; CR closes it
  task automatic send(input string s);
    logic [7:0] c;
    @(posedge clk);
    for (int i = 0; i <= s.len(); i++) begin
      c = (i == s.len()) ? tgc_pkg::CH_CR : s[i];
      rx_valid <= 1'b1;
      rx_data <= c;
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data <= ~c;
  endtask
  task automatic get(output logic [7:0] a, output logic [7:0] b);
    for (int n = 0; n < 200 && ans.size() < 2; n++) @(posedge clk);
    a = ans.size() > 0 ? ans.pop_front() : 8'h00;
    b = ans.size() > 0 ? ans.pop_front() : 8'h00;
  endtask
endmodule // tgc_host

// ==== sim/tb_tgc_handler.sv ====
/* Self-checking bench of the gauge command handler.
   Assumes the host model and checker beside it. */
`timescale 1ns/1ps
module tb_tgc_handler;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, rpt_valid;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] rx_data, tx_data, reg_rdata;
  logic [7:0] reg_wdata = 8'h00;
  tgc_pkg::tgc_sens_t [tgc_pkg::NCH-1:0] sens = '0;
  tgc_pkg::tgc_cfg_t [tgc_pkg::NCH-1:0] cfg;
  logic [tgc_pkg::NCH-1:0] conv_detect, zero_pulse, span_pulse;
  logic [tgc_pkg::NCH-1:0] zp = '0;
  logic [tgc_pkg::NCH-1:0] sp = '0;
  tgc_pkg::tgc_rpt_e rpt_kind;
  logic [3:0] rpt_chan, rc;
  logic [2:0] rk;
  int rn = 0;
  int cyc = 0;
  int nrej = 0;
  int error_cnt = 0;
  int n_tests = 0;
  string gl = "NHA";
  always #2 clk = ~clk;
  tgc_handler dut (.clk, .reset_n, .ce(1'b1), .rx_valid, .rx_data,
    .rx_ready, .tx_valid, .tx_data, .tx_ready, .sens, .cfg, .conv_detect,
    .zero_pulse, .span_pulse, .rpt_valid, .rpt_kind, .rpt_chan, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  tgc_host host (.clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
    .tx_ready);
  always @(posedge clk) begin
    zp <= zp | zero_pulse;
    sp <= sp | span_pulse;
    if (rpt_valid === 1'b1) begin
      rk <= rpt_kind;
      rc <= rpt_chan;
      rn <= rn + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input string s, input logic [7:0] exp);
    tgc_pkg::tgc_cfg_t [tgc_pkg::NCH-1:0] old;
    logic [7:0] a, b;
    old = cfg;
    host.send(s);
    host.get(a, b);
    chk(a, exp);
    chk(b, tgc_pkg::CH_CR);
    if (exp == tgc_pkg::CH_NAK) begin
      nrej++;
      chk(cfg === old, 1);
    end
  endtask
  task automatic req(input string s, input logic [2:0] k, input logic [3:0] c);
    int n0;
    n0 = rn;
    host.send(s);
    for (int i = 0; i < 50 && rn == n0; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(rn - n0, 1);
    chk(rk, k);
    chk(rc, c);
    chk(host.ans.size(), 0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    // Channel 1 Pirani, 2 convection, 3 underrange, 4 absent, 10 present
    sens[0] <= 4'b1100;
    sens[1] <= 4'b1101;
    sens[2] <= 4'b1010;
    sens[9] <= 4'b1100;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(cfg === {tgc_pkg::NCH{tgc_pkg::CFG_RST}}, 1);
    chk(conv_detect, 10'h002);
    rd(tgc_pkg::REG_CTRL, 8'h01);
    rd(4'hf, 8'h00);
    cmd("@0691?", tgc_pkg::CH_NAK);
    cmd("@0811:ON", tgc_pkg::CH_ACK);
    cmd("@0812:ON", tgc_pkg::CH_ACK);
    cmd("@0810:ON", tgc_pkg::CH_ACK);
    chk(cfg[9].power, 1);
    cmd("@0691?", tgc_pkg::ST_PIR);
    cmd("@0692?", tgc_pkg::CH_CV1);
    host.slow = 1'b1;
    cmd("@0682:5", tgc_pkg::CH_ACK);
    cmd("@0692?", tgc_pkg::CH_CV2);
    cmd("@0682:7", tgc_pkg::CH_NAK);
    cmd("@0812:OFF", tgc_pkg::CH_ACK);
    cmd("@0692?", tgc_pkg::CH_NAK);
    cmd("@0561:ON", tgc_pkg::CH_ACK);
    chk(cfg[0].uzero, 1);
    foreach (gl[i]) begin
      cmd({"@0631:", gl.substr(i, i)}, tgc_pkg::CH_ACK);
      chk(cfg[0].gas, i);
    end
    cmd("@0631:X", tgc_pkg::CH_NAK);
    cmd("@0513", tgc_pkg::CH_ACK);
    cmd("@0514", tgc_pkg::CH_NAK);
    chk(zp, 10'h004);
    cmd("@0591:2", tgc_pkg::CH_ACK);
    chk(cfg[0].azref, 4'h1);
    cmd("@0591:4", tgc_pkg::CH_NAK);
    cmd("@0581:E", tgc_pkg::CH_ACK);
    chk(cfg[0].azero, 1);
    cmd("@0581:D", tgc_pkg::CH_ACK);
    chk(cfg[0].azero, 0);
    host.slow = 1'b0;
    cmd("@0571:OFF", tgc_pkg::CH_ACK);
    cmd("@0531", tgc_pkg::CH_ACK);
    chk({sp, 1'(cfg[0].span)}, 11'h003);
    req("@6011?", tgc_pkg::RPT_RDG, 4'h0);
    req("@6021?", tgc_pkg::RPT_RDGTS, 4'h0);
    req("@6081?", tgc_pkg::RPT_STAT, 4'h0);
    req("@6030?", tgc_pkg::RPT_VOLT, 4'h9);
    req("@6063?", tgc_pkg::RPT_LEAK, 4'h2);
    cmd("@6013?", tgc_pkg::CH_NAK);
    cmd("@6033?", tgc_pkg::CH_NAK);
    rd(tgc_pkg::REG_STAT, 8'h02);
    rd(tgc_pkg::REG_REJ, 8'(nrej));
    tally_and_finish();
  end
endmodule // tb_tgc_handler
